/* include/valley_pkg.sv */
// Purpose: constants for the valley-switching turn-on control block
// Assumes: 200 MHz mclk (5 ns period)
// Notes: times kept in ns or kHz as printed; cycle counts derived from them
package valley_pkg;
    localparam int CLK_MHZ = 200;
    localparam int CLK_PERIOD_PS = 5000;
    // frequency-limit oscillator, both variants
    localparam int LIMIT_FREQ_LOW_KHZ = 136;
    localparam int LIMIT_FREQ_HIGH_KHZ = 225;
    localparam int LIMIT_CYC_LOW = (CLK_MHZ * 1000) / LIMIT_FREQ_LOW_KHZ;
    localparam int LIMIT_CYC_HIGH = (CLK_MHZ * 1000) / LIMIT_FREQ_HIGH_KHZ;
    // blanking after turn-off, in ns (2,5 us and 6,3 us)
    localparam int BLANK_SHORT_NS = 2500;
    localparam int BLANK_LONG_NS = 6300;
    localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS * 1000) / CLK_PERIOD_PS;
    localparam int BLANK_LONG_CYC = (BLANK_LONG_NS * 1000) / CLK_PERIOD_PS;
    // turn-on delay after trigger edge, aimed at the drain valley
    localparam int VALLEY_DELAY_NS = 100;
    localparam int VALLEY_DELAY_CYC = (VALLEY_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // starter and minimum frequencies (plain defaults)
    localparam int STARTER_FREQ_KHZ = 20;
    localparam int STARTER_CYC = (CLK_MHZ * 1000) / STARTER_FREQ_KHZ;
    localparam int MIN_FREQ_KHZ = 15;
    localparam int MIN_CYC = (CLK_MHZ * 1000) / MIN_FREQ_KHZ;
    // fixed maximum on-time; ends the pulse if turnOffReq has not come first
    localparam int ON_TIME_NS = 2000;
    localparam int ON_TIME_CYC = (ON_TIME_NS * 1000) / CLK_PERIOD_PS;
    // counter width covers the longest count
    localparam int CNT_W = 16;
    // supply charge current codes
    localparam logic [1:0] CHARGE_OFF = 2'h0;
    localparam logic [1:0] CHARGE_NORMAL = 2'h1; // 3 mA
    localparam logic [1:0] CHARGE_REDUCED = 2'h2; // 0.6 mA

    typedef enum logic [1:0] {
        SUP_CHARGE = 2'b00,
        SUP_RUN = 2'b01,
        SUP_WAIT = 2'b10
    } supply_state_type;
endpackage

/* design/interval_timer.sv */
// Purpose: loadable down-counter with done flag
// Assumes: load wins over counting
// Notes: used for oscillator, blanking, valley delay, starter and on-time
`timescale 1ns/10ps
module interval_timer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [valley_pkg::CNT_W-1:0] loadValue,
    // status
    output logic done
);
    import valley_pkg::*;
    logic [CNT_W-1:0] count_r;

    // count down to zero and hold there
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= loadValue;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    // done is registered so it never depends on the load input combinationally
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done <= 1'b1;
        end else begin
            done <= !load && (count_r <= {{(CNT_W-1){1'b0}}, 1'b1});
        end
    end
endmodule

/* design/valley_turn_on.sv */
// Purpose: turn-on timing of a valley-switching flyback controller
// Assumes: rst_n follows undervoltage lockout; on-time ended by turnOffReq or fixed max
// Notes: highVariant picks the oscillator rate; strapped, sampled while in reset
`timescale 1ns/10ps
module valley_turn_on (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // configuration
    input wire logic highVariant,
    // comparator inputs, already synchronous
    input wire logic armAbove,
    input wire logic triggerBelow,
    input wire logic strobeValid,
    input wire logic strobeAbove1v,
    input wire logic supplyOn,
    input wire logic supplyRestart,
    input wire logic lineStart,
    input wire logic faultSeen,
    input wire logic turnOffReq,
    // outputs
    output logic gateOn_r,
    output logic [1:0] chargeSel_r,
    output logic longBlank_r,
    output logic valleySyncedMode_r
);
    import valley_pkg::*;

    // ----------------------------------------
    // supply start-up and restart
    // ----------------------------------------
    supply_state_type supState_r;
    logic faultRestart_r;
    logic variant_r;

    // strap caught by a clocked process while reset is held
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            variant_r <= highVariant;
        end
    end

    // a fault latches reduced charging for the next restart attempt
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            faultRestart_r <= 1'b0;
        end else if (faultSeen) begin
            faultRestart_r <= 1'b1;
        end else if (supState_r == SUP_CHARGE && supplyOn) begin
            faultRestart_r <= 1'b0;
        end
    end

    // charge, run, then wait for supply to sag below restart level
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            supState_r <= SUP_CHARGE;
            chargeSel_r <= CHARGE_OFF;
        end else begin
            case (supState_r)
                SUP_CHARGE: begin
                    if (supplyOn) begin
                        supState_r <= SUP_RUN;
                        chargeSel_r <= CHARGE_OFF;
                    end else if (lineStart) begin
                        chargeSel_r <= faultRestart_r ? CHARGE_REDUCED : CHARGE_NORMAL;
                    end else begin
                        chargeSel_r <= CHARGE_OFF;
                    end
                end
                SUP_RUN: begin
                    if (!supplyOn || faultSeen) begin
                        supState_r <= SUP_WAIT;
                    end
                end
                SUP_WAIT: begin
                    chargeSel_r <= CHARGE_OFF;
                    if (supplyRestart && lineStart) begin
                        supState_r <= SUP_CHARGE;
                    end
                end
                default: begin
                    supState_r <= SUP_CHARGE;
                    chargeSel_r <= CHARGE_OFF;
                end
            endcase
        end
    end

    wire logic running = (supState_r == SUP_RUN) && !faultSeen;

    // ----------------------------------------
    // edge detect and arming
    // ----------------------------------------
    logic armPrev_r;
    logic trigPrev_r;
    logic armed_r;
    logic turnOnPulse;
    logic turnOffPulse;
    logic oscDone;
    logic blankDone;
    logic delayDone;
    logic delayRun_r;

    wire logic armRise = armAbove && !armPrev_r;
    wire logic trigFall = triggerBelow && !trigPrev_r;
    // inhibit spans the longer of oscillator remainder and blanking
    wire logic inhibit = !oscDone || !blankDone;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armPrev_r <= 1'b0;
            trigPrev_r <= 1'b0;
        end else begin
            armPrev_r <= armAbove;
            trigPrev_r <= triggerBelow;
        end
    end

    // arm on rising edge, consume on any falling edge outside blanking
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armed_r <= 1'b0;
        end else if (gateOn_r || !blankDone) begin
            armed_r <= 1'b0;
        end else if (armRise) begin
            armed_r <= 1'b1;
        end else if (trigFall) begin
            armed_r <= 1'b0;
        end
    end

    // valid trigger starts the valley delay
    wire logic trigTake = running && armed_r && trigFall && !inhibit && !gateOn_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            delayRun_r <= 1'b0;
        end else if (trigTake) begin
            delayRun_r <= 1'b1;
        end else if (delayDone || turnOnPulse) begin
            delayRun_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // starter and protection timing
    // ----------------------------------------
    logic starterDone;
    logic armSeen_r;
    logic stuckHigh_r;

    // armed operation seen since last turn-on; otherwise starter runs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armSeen_r <= 1'b0;
        end else if (turnOnPulse) begin
            armSeen_r <= 1'b0;
        end else if (armRise) begin
            armSeen_r <= 1'b1;
        end
    end

    // sense held above arm level counts as stuck; an off-time rise counts too,
    // otherwise an arm with no trigger after it would stop switching for good
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stuckHigh_r <= 1'b0;
        end else if (turnOffPulse) begin
            stuckHigh_r <= armAbove;
        end else if (armRise && !gateOn_r) begin
            stuckHigh_r <= 1'b1;
        end else if (!armAbove) begin
            stuckHigh_r <= 1'b0;
        end
    end

    wire logic starterFire = !armSeen_r && !stuckHigh_r && starterDone;
    wire logic minFire = stuckHigh_r && starterDone;

    assign turnOnPulse = running && !gateOn_r && blankDone &&
        ((delayRun_r && delayDone) || starterFire || minFire);

    // ----------------------------------------
    // gate and on-time
    // ----------------------------------------
    logic onDone;
    assign turnOffPulse = gateOn_r && (turnOffReq || onDone || !running);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            gateOn_r <= 1'b0;
            valleySyncedMode_r <= 1'b0;
        end else if (turnOnPulse) begin
            gateOn_r <= 1'b1;
            valleySyncedMode_r <= delayRun_r;
        end else if (turnOffPulse) begin
            gateOn_r <= 1'b0;
        end
    end

    // blanking length from the strobed sample of the previous off-time
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            longBlank_r <= 1'b1;
        end else if (strobeValid && !gateOn_r) begin
            longBlank_r <= !strobeAbove1v;
        end
    end

    // ----------------------------------------
    // timers
    // ----------------------------------------
    wire logic [CNT_W-1:0] oscLoad = variant_r ? CNT_W'(LIMIT_CYC_HIGH) : CNT_W'(LIMIT_CYC_LOW);
    wire logic [CNT_W-1:0] blankLoad = longBlank_r ? CNT_W'(BLANK_LONG_CYC)
        : CNT_W'(BLANK_SHORT_CYC);
    wire logic [CNT_W-1:0] starterLoad = stuckHigh_r ? CNT_W'(MIN_CYC) : CNT_W'(STARTER_CYC);

    interval_timer oscTimer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(turnOnPulse),
        .loadValue(oscLoad),
        .done(oscDone)
    );

    interval_timer blankTimer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(turnOffPulse),
        .loadValue(blankLoad),
        .done(blankDone)
    );

    interval_timer delayTimer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(trigTake),
        .loadValue(CNT_W'(VALLEY_DELAY_CYC)),
        .done(delayDone)
    );

    interval_timer starterTimer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(turnOnPulse),
        .loadValue(starterLoad),
        .done(starterDone)
    );

    interval_timer onTimer (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(turnOnPulse),
        .loadValue(CNT_W'(ON_TIME_CYC)),
        .done(onDone)
    );
endmodule

/* dv/sense_model.sv */
// Purpose: winding sense and current-limit stand-in
// Assumes: comparator levels already synchronous to mclk
// Notes: no hysteresis band, so arm and trigger are complements
`timescale 1ns/10ps
module sense_model (
    // clock
    input wire logic mclk,
    // gate and scenario controls
    input wire logic gateOn,
    input wire logic ringOn,
    input wire logic stuckHigh,
    input wire logic [15:0] demagCyc,
    input wire logic [15:0] ringHalf,
    // comparator outputs
    output logic armAbove,
    output logic triggerBelow,
    output logic turnOffReq
);
    int onT;
    int offT;
    bit high;
    bit stop;
    // plateau while demagnetising, then endless ringing; 2-state so defined at time zero
    always_ff @(posedge mclk) begin
        onT <= (gateOn === 1'b1) ? onT + 1 : 0;
        offT <= (gateOn === 1'b1) ? 0 : offT + 1;
        stop <= (gateOn === 1'b1) && onT >= 98; // fixed peak current
        high <= stuckHigh || (ringOn && gateOn !== 1'b1 && (offT < int'(demagCyc)
            || ((offT - int'(demagCyc)) / int'(ringHalf)) % 2 == 1));
    end
    assign armAbove = high;
    assign triggerBelow = !high;
    assign turnOffReq = stop;
endmodule

/* dv/valley_chk.sv */
// Purpose: timing checks on the gate command
// Assumes: highVariant steady outside reset
// Notes: counters in mclk cycles
`timescale 1ns/10ps
module valley_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // inputs
    input wire logic highVariant,
    input wire logic armAbove,
    input wire logic strobeValid,
    input wire logic strobeAbove1v,
    input wire logic lineStart,
    input wire logic faultSeen,
    input wire logic turnOffReq,
    // outputs
    input wire logic gateOn_r,
    input wire logic [1:0] chargeSel_r,
    input wire logic longBlank_r,
    input wire logic valleySyncedMode_r
);
    import valley_pkg::*;
    int sinceOn_r;
    int offCnt_r;
    int onLen_r;
    logic armSeen_r;
    logic armPrev_r;
    logic sample_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // helper counters; sinceOn and offCnt start large so the first turn-on is free
    always_ff @(posedge mclk) begin
        armPrev_r <= armAbove;
        if (!rst_n) begin
            sinceOn_r <= 100000;
            offCnt_r <= 100000;
            onLen_r <= 0;
            armSeen_r <= 1'b0;
            sample_r <= 1'b0;
        end else begin
            sinceOn_r <= $rose(gateOn_r) ? 1 : sinceOn_r + 1;
            offCnt_r <= gateOn_r ? 0 : offCnt_r + 1;
            onLen_r <= gateOn_r ? onLen_r + 1 : 0;
            armSeen_r <= !$rose(gateOn_r) && (armSeen_r || (armAbove && !armPrev_r));
            if (strobeValid) begin
                sample_r <= strobeAbove1v;
            end
        end
    end
    a_osc_limit: assert property ($rose(gateOn_r) |->
        sinceOn_r >= (highVariant ? LIMIT_CYC_HIGH : LIMIT_CYC_LOW)) else $error("turn-on too soon");
    a_blank_hold: assert property ($rose(gateOn_r) |->
        offCnt_r >= BLANK_SHORT_CYC) else $error("turn-on inside blanking");
    a_valley_armed: assert property ($rose(gateOn_r) && valleySyncedMode_r |->
        armSeen_r) else $error("synced turn-on without arming");
    a_blank_pick: assert property ($changed(longBlank_r) |->
        longBlank_r == !sample_r) else $error("blanking choice wrong");
    a_charge_line: assert property ($changed(chargeSel_r) && chargeSel_r != CHARGE_OFF |->
        $past(lineStart)) else $error("charging without line");
    a_fault_stop: assert property (faultSeen |-> ##[1:2] !gateOn_r)
        else $error("gate on during fault");
    a_turnoff_next: assert property (gateOn_r && turnOffReq |=> !gateOn_r)
        else $error("gate held after turn-off");
    a_on_length: assert property (gateOn_r |-> onLen_r <= ON_TIME_CYC)
        else $error("on-time too long");
endmodule

bind valley_turn_on valley_chk valley_chk_inst (.mclk, .rst_n, .highVariant, .armAbove,
    .strobeValid, .strobeAbove1v, .lineStart, .faultSeen, .turnOffReq, .gateOn_r,
    .chargeSel_r, .longBlank_r, .valleySyncedMode_r);

/* dv/valley_turn_on_bench.sv */
// Purpose: self-checking bench for valley_turn_on
// Assumes: sense_model plays winding and current limit
// Notes: periods are mclk cycles between gate rises
`timescale 1ns/10ps
module valley_turn_on_bench;
    import valley_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic highVariant = 1'b0;
    logic strobeValid = 1'b0;
    logic strobeAbove1v = 1'b0;
    logic supplyOn = 1'b0;
    logic supplyRestart = 1'b0;
    logic lineStart = 1'b0;
    logic faultSeen = 1'b0;
    logic ringOn = 1'b0;
    logic stuckHigh = 1'b0;
    logic [15:0] demagCyc = 16'h0578;
    logic [15:0] ringHalf = 16'h0032;
    logic armAbove, triggerBelow, turnOffReq, gateOn_r, longBlank_r, valleySyncedMode_r;
    logic [1:0] chargeSel_r;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int p;
    always #2.5 mclk = ~mclk;
    valley_turn_on valley_turn_on_inst (.mclk, .rst_n, .highVariant, .armAbove, .triggerBelow,
        .strobeValid, .strobeAbove1v, .supplyOn, .supplyRestart, .lineStart, .faultSeen,
        .turnOffReq, .gateOn_r, .chargeSel_r, .longBlank_r, .valleySyncedMode_r);
    sense_model sense_model_inst (.mclk, .gateOn(gateOn_r), .ringOn, .stuckHigh, .demagCyc,
        .ringHalf, .armAbove, .triggerBelow, .turnOffReq);
    // ----------
    // helpers
    // ----------
    task automatic span(input string what, input int lo, input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // bounded wait: a missing turn-on returns a count that fails any span
    task automatic next_rise(output int n);
        bit low;
        n = 0;
        low = 1'b0;
        do begin
            tick(1);
            n++;
            if (gateOn_r === 1'b0) begin
                low = 1'b1;
            end
        end while (!(low && gateOn_r === 1'b1) && n < 30000);
    endtask
    task automatic measure(input string what, input int lo, input int hi, input logic vs);
        next_rise(p);
        next_rise(p);
        span(what, lo, hi, p);
        span("synced flag", vs, vs, (valleySyncedMode_r === vs) ? vs : 2);
        $display("%s test done", what);
    endtask
    task automatic do_reset(input logic hv);
        @(posedge mclk);
        rst_n <= 1'b0;
        highVariant <= hv;
        {supplyOn, lineStart, supplyRestart, ringOn, stuckHigh} <= 5'h00;
        tick(10);
        span("blank in reset", 1, 1, (longBlank_r === 1'b1));
        @(posedge mclk);
        rst_n <= 1'b1;
    endtask
    task automatic power_up;
        @(posedge mclk);
        lineStart <= 1'b1;
        tick(3);
        span("charge normal", 1, 1, (chargeSel_r === CHARGE_NORMAL));
        @(posedge mclk);
        supplyOn <= 1'b1;
        tick(3);
        span("charge off running", 1, 1, (chargeSel_r === CHARGE_OFF));
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic ring_test(input logic [15:0] dm, input logic [15:0] rh);
        @(posedge mclk);
        ringOn <= 1'b1;
        demagCyc <= dm;
        ringHalf <= rh;
    endtask
    task automatic fault_test;
        @(posedge mclk);
        faultSeen <= 1'b1;
        supplyOn <= 1'b0;
        tick(3);
        span("gate after fault", 1, 1, (gateOn_r === 1'b0));
        span("no charge above restart", 1, 1, (chargeSel_r === CHARGE_OFF));
        @(posedge mclk);
        supplyRestart <= 1'b1;
        faultSeen <= 1'b0;
        tick(3);
        span("charge reduced", 1, 1, (chargeSel_r === CHARGE_REDUCED));
        @(posedge mclk);
        supplyOn <= 1'b1;
        supplyRestart <= 1'b0;
        $display("fault test done");
    endtask
    task automatic blank_test(input logic hi1v, input int lo, input int hi);
        next_rise(p);
        tick(150);
        @(posedge mclk);
        strobeValid <= 1'b1;
        strobeAbove1v <= hi1v;
        @(posedge mclk);
        strobeValid <= 1'b0;
        measure("blanking", lo, hi, 1'b1);
        span("blank choice", 1, 1, (longBlank_r === !hi1v));
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard, well above the expected run length
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 98000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        do_reset(1'b0);
        power_up();
        measure("starter", STARTER_CYC - 3, STARTER_CYC + 3, 1'b0);
        ring_test(16'h0578, 16'h0032);
        measure("valley", 1600, 1660, 1'b1);
        ring_test(16'h00C8, 16'h0046);
        measure("skip", LIMIT_CYC_LOW, LIMIT_CYC_LOW + 180, 1'b1);
        fault_test();
        stuckHigh <= 1'b1;
        measure("stuck", MIN_CYC - 3, MIN_CYC + 3, 1'b0);
        do_reset(1'b1);
        power_up();
        ring_test(16'h00C8, 16'h0064);
        blank_test(1'b1, LIMIT_CYC_HIGH, 960);
        blank_test(1'b0, 1361, 1560);
        complete_run();
    end
endmodule
